// >>> src/drive_start_pkg.sv
// Constants, register map and types for the start/stop command decoder.
package drive_start_pkg;
    // ------------------------------------------------------------------
    // Clock and timebase
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 100_000_000;
    localparam int unsigned SEC_TIME_S  = 1;
    localparam int unsigned SEC_CYCLES  = SEC_TIME_S * CLK_HZ;
    localparam int unsigned TICK_W      = 27;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W      = 4;
    localparam logic [3:0]  OFS_STOPSEL = 4'h0;
    localparam logic [3:0]  OFS_TERMSEL = 4'h4;
    localparam logic [3:0]  OFS_STATUS  = 4'h8;

    // ------------------------------------------------------------------
    // Stop-selection setting
    // ------------------------------------------------------------------
    localparam int unsigned SEL_W        = 14;
    localparam logic [13:0] SEL_COAST_MAX = 14'h0064;
    localparam logic [13:0] SEL_DIR_MIN   = 14'h03e8;
    localparam logic [13:0] SEL_DIR_MAX   = 14'h044c;
    localparam logic [13:0] SEL_DECEL_PD  = 14'h270f;
    localparam logic [13:0] SEL_DECEL_SD  = 14'h22b8;
    localparam logic [13:0] SEL_RESET     = SEL_DECEL_PD;

    // ------------------------------------------------------------------
    // Terminal function selection register fields
    // ------------------------------------------------------------------
    localparam int unsigned TS_FIRST_LSB  = 0;
    localparam int unsigned TS_SECOND_LSB = 8;
    localparam int unsigned TS_AUX_LSB    = 16;
    localparam int unsigned TS_JOGEN_BIT  = 24;
    localparam logic [7:0]  FUNC_FWD      = 8'h3c;
    localparam logic [7:0]  FUNC_REV      = 8'h3d;
    localparam logic [7:0]  FUNC_STOP     = 8'h19;
    localparam logic [24:0] TERMSEL_RESET = {1'b0, FUNC_STOP, FUNC_REV, FUNC_FWD};

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int unsigned ST_SECS_LSB   = 16;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {
        RUN_IDLE  = 2'b00,
        RUN_GO    = 2'b01,
        RUN_DECEL = 2'b10,
        RUN_COAST = 2'b11
    } run_state_type;
endpackage : drive_start_pkg

// >>> src/drive_start_stop_decoder.sv
// Start/stop command decoder with AXI4-Lite configuration and status registers.
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
module drive_start_stop_decoder #(
    parameter int unsigned TICK_CYCLES = drive_start_pkg::SEC_CYCLES
) (
    input  wire logic                                clk_sys,          // System clock, 100 MHz.
    input  wire logic                                sys_rst,          // Synchronous reset, active high.
    input  wire logic                                forwardStartIn,   // Forward start terminal.
    input  wire logic                                reverseStartIn,   // Reverse start terminal.
    input  wire logic                                auxTermIn,        // Multi-function terminal, stop when coded.
    input  wire logic                                jogIn,            // Jog terminal.
    input  wire logic                                outputShutoffIn,  // Output shutoff terminal.
    input  wire logic                                rampZeroIn,       // Drive reports zero speed.
    output logic                                     runCmd,           // Drive commanded to run.
    output logic                                     dirReverse,       // Commanded direction is reverse.
    output logic                                     decelStop,        // Ramping down to a stop.
    output logic                                     coastStop,        // Output off, motor coasting.
    output logic                                     outputEnable,     // Power stage may switch.
    input  wire logic [drive_start_pkg::ADDR_W-1:0] s_axi_awaddr,     // Write address.
    input  wire logic                                s_axi_awvalid,    // Write address valid.
    output logic                                     s_axi_awready,    // Write address ready.
    input  wire logic [31:0]                         s_axi_wdata,      // Write data.
    input  wire logic [3:0]                          s_axi_wstrb,      // Write byte strobes.
    input  wire logic                                s_axi_wvalid,     // Write data valid.
    output logic                                     s_axi_wready,     // Write data ready.
    output logic [1:0]                               s_axi_bresp,      // Write response.
    output logic                                     s_axi_bvalid,     // Write response valid.
    input  wire logic                                s_axi_bready,     // Write response ready.
    input  wire logic [drive_start_pkg::ADDR_W-1:0] s_axi_araddr,     // Read address.
    input  wire logic                                s_axi_arvalid,    // Read address valid.
    output logic                                     s_axi_arready,    // Read address ready.
    output logic [31:0]                              s_axi_rdata,      // Read data.
    output logic [1:0]                               s_axi_rresp,      // Read response.
    output logic                                     s_axi_rvalid,     // Read data valid.
    input  wire logic                                s_axi_rready      // Read data ready.
);
    import drive_start_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res;
    endfunction : mergeBytes

    function automatic logic isStartDir(input logic [SEL_W-1:0] s);
        return (s == SEL_DECEL_SD) || (s >= SEL_DIR_MIN && s <= SEL_DIR_MAX);
    endfunction : isStartDir

    function automatic logic isCoast(input logic [SEL_W-1:0] s);
        return (s <= SEL_COAST_MAX) || (s >= SEL_DIR_MIN && s <= SEL_DIR_MAX);
    endfunction : isCoast

    function automatic logic [6:0] coastDelay(input logic [SEL_W-1:0] s);
        logic [SEL_W-1:0] d;
        d = (s >= SEL_DIR_MIN) ? s - SEL_DIR_MIN : s;
        return d[6:0];
    endfunction : coastDelay

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [4:0]        syncAQ;
    logic [4:0]        syncBQ;
    logic [4:0]        syncCQ;
    logic [4:0]        pinLvlQ;
    logic [SEL_W-1:0]  stopSelQ;
    logic [24:0]       termSelQ;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            syncAQ  <= 5'h00;
            syncBQ  <= 5'h00;
            syncCQ  <= 5'h00;
            pinLvlQ <= 5'h00;
        end else begin
            syncAQ  <= {outputShutoffIn, jogIn, auxTermIn, reverseStartIn, forwardStartIn};
            syncBQ  <= syncAQ;
            syncCQ  <= syncBQ;
            pinLvlQ <= (syncBQ & syncCQ) | (pinLvlQ & (syncBQ ^ syncCQ));
        end
    end

    logic shutLvl;
    logic jogLvl;
    logic fwdEn;
    logic revEn;
    logic stopValid;
    logic perDir;
    logic coastMode;
    assign shutLvl = pinLvlQ[4];
    assign jogLvl  = pinLvlQ[3];
    assign fwdEn = pinLvlQ[0] && (termSelQ[TS_FIRST_LSB +: 8] == FUNC_FWD);
    assign revEn = pinLvlQ[1] && (termSelQ[TS_SECOND_LSB +: 8] == FUNC_REV);
    assign stopValid = pinLvlQ[2] && (termSelQ[TS_AUX_LSB +: 8] == FUNC_STOP)
                       && !(jogLvl && termSelQ[TS_JOGEN_BIT]);
    assign perDir    = !isStartDir(stopSelQ);
    assign coastMode = isCoast(stopSelQ);

    // ------------------------------------------------------------------
    // Self-holding start latch
    // ------------------------------------------------------------------
    logic fwdPrevQ;
    logic revPrevQ;
    logic holdQ;
    logic holdRevQ;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            fwdPrevQ <= 1'b0;
            revPrevQ <= 1'b0;
        end else begin
            fwdPrevQ <= fwdEn;
            revPrevQ <= revEn;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            holdQ    <= 1'b0;
            holdRevQ <= 1'b0;
        end else if (!stopValid) begin
            // shutoff is never a clear term
            holdQ    <= 1'b0;
            holdRevQ <= 1'b0;
        end else if (fwdPrevQ && !fwdEn) begin
            holdQ    <= 1'b1;
            holdRevQ <= 1'b0;
        end else if (revPrevQ && !revEn) begin
            holdQ    <= 1'b1;
            holdRevQ <= 1'b1;
        end
    end

    logic reqRun;
    logic reqRev;
    always_comb begin
        if (stopValid) begin
            reqRun = holdQ;
            reqRev = holdRevQ;
        end else if (perDir) begin
            reqRun = fwdEn ^ revEn;
            reqRev = revEn;
        end else begin
            reqRun = fwdEn;
            reqRev = revEn;
        end
    end

    // ------------------------------------------------------------------
    // Run state and stop method
    // ------------------------------------------------------------------
    run_state_type       stateQ;
    logic [6:0]          secLeftQ;
    logic [TICK_W-1:0]   tickCntQ;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stateQ <= RUN_IDLE;
        end else begin
            unique case (stateQ)
                RUN_IDLE: begin
                    if (reqRun) begin
                        stateQ <= RUN_GO;
                    end
                end
                RUN_GO: begin
                    if (!reqRun) begin
                        stateQ <= RUN_DECEL;
                    end
                end
                RUN_DECEL: begin
                    if (reqRun) begin
                        stateQ <= RUN_GO;
                    end else if (coastMode && secLeftQ == 7'h00) begin
                        stateQ <= RUN_COAST;
                    end else if (rampZeroIn) begin
                        stateQ <= RUN_IDLE;
                    end
                end
                RUN_COAST: begin
                    if (reqRun) begin
                        stateQ <= RUN_GO;
                    end else if (rampZeroIn) begin
                        stateQ <= RUN_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            secLeftQ <= 7'h00;
            tickCntQ <= '0;
        end else if (stateQ == RUN_GO && !reqRun) begin
            secLeftQ <= coastDelay(stopSelQ);
            tickCntQ <= '0;
        end else if (stateQ == RUN_DECEL && secLeftQ != 7'h00) begin
            if (tickCntQ == TICK_W'(TICK_CYCLES - 1)) begin
                tickCntQ <= '0;
                secLeftQ <= secLeftQ - 7'h01;
            end else begin
                tickCntQ <= tickCntQ + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dirReverse <= 1'b0;
        end else if (reqRun) begin
            dirReverse <= reqRev;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            runCmd       <= 1'b0;
            decelStop    <= 1'b0;
            coastStop    <= 1'b0;
            outputEnable <= 1'b0;
        end else begin
            runCmd       <= (stateQ == RUN_GO);
            decelStop    <= (stateQ == RUN_DECEL);
            coastStop    <= (stateQ == RUN_COAST);
            outputEnable <= !shutLvl && (stateQ != RUN_COAST);
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    logic              awHeldQ;
    logic              wHeldQ;
    logic [ADDR_W-1:0] awAddrQ;
    logic [31:0]       wDataQ;
    logic [3:0]        wStrbQ;
    logic              doWrite;

    assign s_axi_awready = !awHeldQ && !s_axi_bvalid;
    assign s_axi_wready  = !wHeldQ && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign doWrite       = awHeldQ && wHeldQ && !s_axi_bvalid;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            awHeldQ <= 1'b0;
            wHeldQ  <= 1'b0;
            awAddrQ <= '0;
            wDataQ  <= 32'h0000_0000;
            wStrbQ  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeldQ <= 1'b1;
                awAddrQ <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeldQ <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeldQ <= 1'b1;
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeldQ <= 1'b0;
            end
        end
    end

    // A function result cannot be part-selected, so the merged words get names first.
    logic [31:0] stopSelMerged;
    logic [31:0] termSelMerged;
    assign stopSelMerged = mergeBytes({18'h0, stopSelQ}, wDataQ, wStrbQ);
    assign termSelMerged = mergeBytes({7'h0, termSelQ}, wDataQ, wStrbQ);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stopSelQ <= SEL_RESET;
            termSelQ <= TERMSEL_RESET;
        end else if (doWrite) begin
            if (awAddrQ == OFS_STOPSEL) begin
                stopSelQ <= stopSelMerged[SEL_W-1:0];
            end else if (awAddrQ == OFS_TERMSEL) begin
                termSelQ <= termSelMerged[24:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddrQ == OFS_STOPSEL || awAddrQ == OFS_TERMSEL) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic [31:0] statusWord;
    assign statusWord = {9'h000, secLeftQ, 8'h00, stopValid, holdRevQ, holdQ, shutLvl,
                         outputEnable, coastStop, decelStop, runCmd};

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            unique case (s_axi_araddr)
                OFS_STOPSEL: s_axi_rdata <= {18'h0, stopSelQ};
                OFS_TERMSEL: s_axi_rdata <= {7'h0, termSelQ};
                OFS_STATUS:  s_axi_rdata <= {statusWord[31:9], dirReverse, statusWord[7:0]};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    per_dir_run_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
        (stateQ == RUN_IDLE && !stopValid && perDir && (fwdEn ^ revEn)) |=> ##1 (runCmd && dirReverse == $past(revEn, 2)))
        else $error("single start input did not start the drive");

    per_dir_both_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
        (stateQ == RUN_GO && !stopValid && perDir && fwdEn && revEn) |=> ##1 decelStop)
        else $error("both start inputs did not decelerate");

    start_dir_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!stopValid && !perDir && fwdEn) |=> (dirReverse == $past(revEn)))
        else $error("direction input not followed");

    no_coast_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
        (stopSelQ == SEL_DECEL_PD && stateQ == RUN_DECEL && !reqRun) |=> (stateQ != RUN_COAST))
        else $error("decelerating setting entered coast");

    coast_delay_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
        (stateQ == RUN_DECEL && coastMode && secLeftQ == 7'h00 && !reqRun) |=> ##1 (coastStop && !outputEnable))
        else $error("coast not reached after delay");

    delay_load_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
        (stateQ == RUN_GO && !reqRun) |=> (secLeftQ == coastDelay($past(stopSelQ)) && tickCntQ == '0))
        else $error("coast delay loaded wrong");

    hold_latch_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
        (stopValid && fwdPrevQ && !fwdEn) |=> (holdQ && !holdRevQ))
        else $error("forward release not latched");

    hold_clear_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
        (holdQ && !stopValid) |=> (!holdQ ##1 !runCmd))
        else $error("stop release did not clear latch");

    shutoff_keep_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
        (holdQ && stopValid && shutLvl) ##1 stopValid |-> holdQ)
        else $error("shutoff cleared the latch");

    shutoff_out_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
        shutLvl |=> !outputEnable)
        else $error("output still enabled under shutoff");
endmodule : drive_start_stop_decoder

// >>> testbench/start_switch_panel.sv
// Behavioural model of the switches that drive the start, stop and jog terminals.
`timescale 1ns/1ps
module start_switch_panel (
    input  wire logic clk_sys, // System clock.
    output logic      fwdPin,  // Forward start switch.
    output logic      revPin,  // Reverse start switch.
    output logic      stopPin, // Stop switch on the aux terminal.
    output logic      jogPin   // Jog switch.
);
    initial begin
        fwdPin = 1'b0;
        revPin = 1'b0;
        stopPin = 1'b0;
        jogPin = 1'b0;
    end
    // Switch levels change just after a clock edge and then hold.
    task automatic set_pins(input logic f, input logic r, input logic s, input logic j);
        @(posedge clk_sys);
        fwdPin <= f;
        revPin <= r;
        stopPin <= s;
        jogPin <= j;
    endtask : set_pins
    task automatic pulse_start(input logic toReverse);
        @(posedge clk_sys);
        if (toReverse) revPin <= 1'b1;
        else fwdPin <= 1'b1;
        repeat (8) @(posedge clk_sys);
        fwdPin <= 1'b0;
        revPin <= 1'b0;
    endtask : pulse_start
endmodule : start_switch_panel

// >>> testbench/drive_start_stop_decoder_tb.sv
// Self-checking bench for the start/stop command decoder.
`timescale 1ns/1ps
module drive_start_stop_decoder_tb;
    import drive_start_pkg::*;
    localparam int TK = 10;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        shutoff = 1'b0;
    logic        rampZero = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        fwd, rev, aux, jog, runCmd, dirReverse, decelStop, coastStop, outputEnable;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [31:0] rdata;
    logic [1:0]  bresp, rresp;
    int          failCount = 0;
    int          samplesChecked = 0;
    wire logic [3:0] outs = {runCmd, dirReverse, decelStop, coastStop};

    always #5 clk_sys = ~clk_sys;

    start_switch_panel pnl (.clk_sys(clk_sys), .fwdPin(fwd), .revPin(rev), .stopPin(aux), .jogPin(jog));
    drive_start_stop_decoder #(.TICK_CYCLES(TK)) dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .forwardStartIn(fwd), .reverseStartIn(rev),
        .auxTermIn(aux), .jogIn(jog), .outputShutoffIn(shutoff), .rampZeroIn(rampZero),
        .runCmd(runCmd), .dirReverse(dirReverse), .decelStop(decelStop), .coastStop(coastStop),
        .outputEnable(outputEnable), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    task automatic results();
        $display("checks %0d mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            failCount++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic bound(input int n);
        if (n >= 80) begin
            chk("wait bound", 0, 1);
            results();
        end
    endtask : bound
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 80; n++) begin
            @(posedge clk_sys);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bound(n);
        bready <= 1'b0;
        chk("bresp", bresp, er);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 80; n++) begin
            @(posedge clk_sys);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        bound(n);
        rready <= 1'b0;
        chk("rdata", rdata, exp);
        chk("rresp", rresp, er);
    endtask : rd
    task automatic idle();
        pnl.set_pins(0, 0, 0, 0);
        shutoff <= 1'b0;
        rampZero <= 1'b1;
        tick(8);
        rampZero <= 1'b0;
        chk("idle", {runCmd, decelStop, coastStop}, 3'b000);
    endtask : idle
    task automatic drive(input logic f, input logic r, input logic s, input logic j);
        pnl.set_pins(f, r, s, j);
        tick(8);
    endtask : drive
    task automatic s_regs();
        rd(OFS_STOPSEL, 32'h0000270f, RESP_OKAY);
        rd(OFS_TERMSEL, {8'h00, 8'h19, FUNC_REV, FUNC_FWD}, RESP_OKAY);
        rd(OFS_STATUS, 32'h00000008, RESP_OKAY);
        rd(4'hc, 32'h0, RESP_SLVERR);
        wr(OFS_STATUS, 32'hffffffff, RESP_SLVERR);
    endtask : s_regs
    task automatic s_two();
        drive(1, 0, 0, 0);
        chk("fwd run", outs, 4'b1000);
        drive(1, 1, 0, 0);
        chk("both on", outs, 4'b0010);
        idle();
        drive(0, 1, 0, 0);
        chk("rev run", outs, 4'b1100);
        drive(0, 0, 0, 0);
        tick(40);
        chk("release", {runCmd, decelStop, coastStop}, 3'b010);
        idle();
    endtask : s_two
    task automatic s_coast(input logic [13:0] sel, input int secs);
        int n;
        wr(OFS_STOPSEL, {18'h0, sel}, RESP_OKAY);
        drive(1, 0, 0, 0);
        chk("run", runCmd, 1'b1);
        pnl.set_pins(0, 0, 0, 0);
        tick(secs * TK);
        chk("early coast", coastStop, 1'b0);
        for (n = 0; n < 80 && coastStop !== 1'b1; n++) @(posedge clk_sys);
        bound(n);
        chk("coast late", n <= 10, 1);
        chk("output off", outputEnable, 1'b0);
        idle();
    endtask : s_coast
    task automatic s_dir();
        wr(OFS_STOPSEL, 32'h000022b8, RESP_OKAY);
        drive(1, 1, 0, 0);
        chk("start rev", outs, 4'b1100);
        drive(1, 0, 0, 0);
        chk("start fwd", outs, 4'b1000);
        drive(0, 1, 0, 0);
        tick(40);
        chk("no start", {runCmd, decelStop, coastStop}, 3'b010);
        idle();
    endtask : s_dir
    task automatic s_hold();
        wr(OFS_STOPSEL, 32'h0000270f, RESP_OKAY);
        drive(0, 0, 1, 0);
        pnl.pulse_start(0);
        tick(8);
        chk("held fwd", outs, 4'b1000);
        pnl.pulse_start(1);
        tick(8);
        chk("held rev", outs, 4'b1100);
        shutoff <= 1'b1;
        tick(8);
        chk("shut", {runCmd, outputEnable}, 2'b10);
        shutoff <= 1'b0;
        tick(8);
        chk("resume", {runCmd, outputEnable}, 2'b11);
        drive(0, 0, 0, 0);
        chk("stop", {runCmd, decelStop}, 2'b01);
        idle();
    endtask : s_hold
    task automatic s_gate(input logic [31:0] sel, input logic j, input logic s);
        wr(OFS_TERMSEL, sel, RESP_OKAY);
        drive(0, 0, s, j);
        pnl.pulse_start(0);
        tick(8);
        chk("gated", runCmd, 1'b0);
        idle();
    endtask : s_gate

    initial begin
        tick(6);
        sys_rst <= 1'b0;
        tick(4);
        s_regs();
        idle();
        s_two();
        s_coast(14'h0003, 3);
        s_coast(14'h03ea, 2);
        s_dir();
        s_hold();
        s_gate(32'h00183d3c, 1'b0, 1'b1);
        s_gate(32'h01193d3c, 1'b1, 1'b1);
        s_gate(32'h00193d3e, 1'b0, 1'b1);
        results();
    end
endmodule : drive_start_stop_decoder_tb
